// ===== fam_defs.svh
// register offsets, field positions and reset values of the fault address block
`ifndef FAM_DEFS_SVH
`define FAM_DEFS_SVH

`define FAM_OFS_MMADDR 12'h000
`define FAM_OFS_BFADDR 12'h004
`define FAM_OFS_STATUS 12'h008
`define FAM_OFS_MASK 12'h00C
`define FAM_OFS_ATTR 12'h010

`define FAM_MM_CAUSE_W 5
`define FAM_BF_CAUSE_W 6
`define FAM_MM_CAUSE_LSB 0
`define FAM_MM_VALID_BIT 7
`define FAM_BF_CAUSE_LSB 8
`define FAM_BF_VALID_BIT 15
`define FAM_STAT_W 16

`define FAM_ADDR_RESET 32'h0000_0000
`define FAM_STAT_RESET 16'h0000
`define FAM_MASK_RESET 16'h0000

`define FAM_ATTR_SHARE_BIT 0
`define FAM_ATTR_TYPE_LSB 4
`define FAM_ATTR_INNER_LSB 8
`define FAM_ATTR_OUTER_LSB 12

`endif

// ===== fam_pkg.sv
// types shared by the fault address and attribute decode block
package fam_pkg;
  typedef enum logic [1:0] {
    FAM_STRONG_ORDER,
    FAM_DEVICE,
    FAM_NORMAL,
    FAM_RESERVED
  } fam_mem_type_t;

  typedef enum logic [1:0] {
    FAM_NON_CACHE,
    FAM_WB_RW_ALLOC,
    FAM_WT_NO_ALLOC,
    FAM_WB_NO_ALLOC
  } fam_policy_t;
endpackage

// ===== fam_policy_dec.sv
// decodes one two-bit cache policy field into a policy
`timescale 1ns/100ps
module fam_policy_dec (
  input wire logic [1:0] policyBits, // two-bit inner or outer field
  output fam_pkg::fam_policy_t policy // decoded cache policy
);
  import fam_pkg::*;

  always_comb begin
    case (policyBits)
      2'h0: policy = FAM_NON_CACHE;
      2'h1: policy = FAM_WB_RW_ALLOC;
      2'h2: policy = FAM_WT_NO_ALLOC;
      default: policy = FAM_WB_NO_ALLOC;
    endcase
  end
endmodule // fam_policy_dec

// ===== fam_fault_addr.sv
// fault address capture, fault status flags and memory attribute decode
//
// Functional notes
// - memmanage address register holds faulting address while its valid flag is one.
// - unaligned memmanage fault records the actual faulting piece address.
// - memfault status sub holds cause flags and the address valid flag.
// - bus fault address register holds faulting address while its valid flag is one.
// - unaligned bus fault records the address requested by the instruction.
// - tex 000, C0: B0 strongly-ordered shareable, B1 device shareable.
// - tex 000, C1 B0: normal write-through, no write allocate, S shareability.
// - tex 000, C1 B1: normal write-back, no write allocate, S shareability.
// - tex 001, C1 B1: normal write-back, read and write allocate.
// - tex 4..7 policy fields: 00 NC, 01 WB-RWA, 10 WT, 11 WB.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`include "fam_defs.svh"
`timescale 1ns/100ps
module fam_fault_addr (
  input wire logic core_clk, // core clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  // apb slave
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  // fault reports from the load/store path
  input wire logic memFault, // memmanage fault event pulse
  input wire logic [`FAM_MM_CAUSE_W-1:0] memFaultCause, // memmanage cause flags
  input wire logic memFaultAddrOk, // fault address is meaningful
  input wire logic [31:0] memFaultAddr, // actual faulting piece address
  input wire logic busFault, // bus fault event pulse
  input wire logic [`FAM_BF_CAUSE_W-1:0] busFaultCause, // bus fault cause flags
  input wire logic busFaultAddrOk, // fault address is meaningful
  input wire logic [31:0] busFaultReqAddr, // address requested by instruction
  // region attributes of the current access
  input wire logic [2:0] typeExtensionField, // type extension bits
  input wire logic regionCacheable, // cacheable bit
  input wire logic regionBufferable, // bufferable bit
  input wire logic regionShareable, // shareable bit
  output fam_pkg::fam_mem_type_t memType, // decoded memory type
  output logic memShareable, // decoded shareability
  output fam_pkg::fam_policy_t innerPolicy, // decoded inner cache policy
  output fam_pkg::fam_policy_t outerPolicy, // decoded outer cache policy
  output logic irq // level interrupt
);
  import fam_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] memmanageFaultAddress_q;
  logic [31:0] memmanageFaultAddress_d;
  logic [31:0] busFaultAddress_q;
  logic [31:0] busFaultAddress_d;
  logic [`FAM_STAT_W-1:0] status_q;
  logic [`FAM_STAT_W-1:0] status_d;
  logic [`FAM_STAT_W-1:0] mask_q;
  logic [`FAM_STAT_W-1:0] mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic slverr_q;
  logic slverr_d;
  fam_mem_type_t memType_q;
  fam_mem_type_t memType_d;
  logic share_q;
  logic share_d;
  fam_policy_t inner_q;
  fam_policy_t inner_d;
  fam_policy_t outer_q;
  fam_policy_t outer_d;

  logic setupPhase;
  logic accessPhase;
  logic wrAccess;
  logic rdStatus;
  logic [`FAM_STAT_W-1:0] statusSet;
  logic [`FAM_STAT_W-1:0] memSet;
  logic [`FAM_STAT_W-1:0] busSet;
  logic [31:0] attrWord;
  logic [31:0] maskMerged;
  fam_policy_t hiPolicyOuter;
  fam_policy_t hiPolicyInner;

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign wrAccess = accessPhase & pwrite;
  // zero wait states: data is prepared during the setup cycle
  assign pready = accessPhase;
  assign prdata = rdata_q;
  assign pslverr = slverr_q & accessPhase;

  // byte-strobe merge of a write into a word
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wdata[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // fault capture
  // ----------------------------------------
  always_comb begin
    memSet = '0;
    memSet[`FAM_MM_CAUSE_LSB +: `FAM_MM_CAUSE_W] = memFaultCause;
    memSet[`FAM_MM_VALID_BIT] = memFaultAddrOk;
    busSet = '0;
    busSet[`FAM_BF_CAUSE_LSB +: `FAM_BF_CAUSE_W] = busFaultCause;
    busSet[`FAM_BF_VALID_BIT] = busFaultAddrOk;
    statusSet = (memFault ? memSet : '0) | (busFault ? busSet : '0);
  end

  assign rdStatus = accessPhase & ~pwrite & (paddr == `FAM_OFS_STATUS);

  always_comb begin
    memmanageFaultAddress_d = memmanageFaultAddress_q;
    busFaultAddress_d = busFaultAddress_q;
    mask_d = mask_q;
    maskMerged = mergeBytes({16'h0000, mask_q}, pwdata, pstrb);
    if (wrAccess && paddr == `FAM_OFS_MMADDR) begin
      memmanageFaultAddress_d = mergeBytes(memmanageFaultAddress_q, pwdata, pstrb);
    end
    if (wrAccess && paddr == `FAM_OFS_BFADDR) begin
      busFaultAddress_d = mergeBytes(busFaultAddress_q, pwdata, pstrb);
    end
    if (wrAccess && paddr == `FAM_OFS_MASK) begin
      mask_d = maskMerged[`FAM_STAT_W-1:0];
    end
    // a fault in the same cycle as a software write wins
    if (memFault && memFaultAddrOk) begin
      memmanageFaultAddress_d = memFaultAddr;
    end
    if (busFault && busFaultAddrOk) begin
      busFaultAddress_d = busFaultReqAddr;
    end
    // read clears only the bits it returned, so a flag set after setup survives
    status_d = (status_q & ~(rdStatus ? rdata_q[`FAM_STAT_W-1:0] : '0)) | statusSet;
  end

  // ----------------------------------------
  // attribute decode
  // ----------------------------------------
  fam_policy_dec outerDec (
    .policyBits(typeExtensionField[1:0]),
    .policy(hiPolicyOuter)
  );

  fam_policy_dec innerDec (
    .policyBits({regionCacheable, regionBufferable}),
    .policy(hiPolicyInner)
  );

  always_comb begin
    memType_d = FAM_RESERVED;
    share_d = regionShareable;
    inner_d = FAM_NON_CACHE;
    outer_d = FAM_NON_CACHE;
    if (typeExtensionField[2]) begin
      memType_d = FAM_NORMAL;
      outer_d = hiPolicyOuter;
      inner_d = hiPolicyInner;
    end else begin
      case ({typeExtensionField[1:0], regionCacheable, regionBufferable})
        4'h0: begin
          memType_d = FAM_STRONG_ORDER;
          share_d = 1'b1;
        end
        4'h1: begin
          memType_d = FAM_DEVICE;
          share_d = 1'b1;
        end
        4'h2: begin
          memType_d = FAM_NORMAL;
          inner_d = FAM_WT_NO_ALLOC;
          outer_d = FAM_WT_NO_ALLOC;
        end
        4'h3: begin
          memType_d = FAM_NORMAL;
          inner_d = FAM_WB_NO_ALLOC;
          outer_d = FAM_WB_NO_ALLOC;
        end
        4'h4: begin
          memType_d = FAM_NORMAL;
        end
        4'h7: begin
          memType_d = FAM_NORMAL;
          inner_d = FAM_WB_RW_ALLOC;
          outer_d = FAM_WB_RW_ALLOC;
        end
        4'h8: begin
          // non-shareable device encoding with shareable ignored
          memType_d = FAM_DEVICE;
          share_d = 1'b0;
        end
        default: begin
          // reserved and implementation defined encodings
          memType_d = FAM_RESERVED;
          share_d = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read mux and decode
  // ----------------------------------------
  always_comb begin
    attrWord = '0;
    attrWord[`FAM_ATTR_SHARE_BIT] = share_q;
    attrWord[`FAM_ATTR_TYPE_LSB +: 2] = memType_q;
    attrWord[`FAM_ATTR_INNER_LSB +: 2] = inner_q;
    attrWord[`FAM_ATTR_OUTER_LSB +: 2] = outer_q;
    rdata_d = rdata_q;
    slverr_d = slverr_q;
    if (setupPhase) begin
      slverr_d = 1'b0;
      case (paddr)
        `FAM_OFS_MMADDR: rdata_d = memmanageFaultAddress_q;
        `FAM_OFS_BFADDR: rdata_d = busFaultAddress_q;
        `FAM_OFS_STATUS: rdata_d = {16'h0000, status_q};
        `FAM_OFS_MASK: rdata_d = {16'h0000, mask_q};
        `FAM_OFS_ATTR: rdata_d = attrWord;
        default: begin
          rdata_d = 32'h0000_0000;
          slverr_d = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      memmanageFaultAddress_q <= `FAM_ADDR_RESET;
      busFaultAddress_q <= `FAM_ADDR_RESET;
      status_q <= `FAM_STAT_RESET;
      mask_q <= `FAM_MASK_RESET;
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
      memType_q <= FAM_STRONG_ORDER;
      share_q <= 1'b1;
      inner_q <= FAM_NON_CACHE;
      outer_q <= FAM_NON_CACHE;
    end else begin
      memmanageFaultAddress_q <= memmanageFaultAddress_d;
      busFaultAddress_q <= busFaultAddress_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
      memType_q <= memType_d;
      share_q <= share_d;
      inner_q <= inner_d;
      outer_q <= outer_d;
    end
  end

  assign memType = memType_q;
  assign memShareable = share_q;
  assign innerPolicy = inner_q;
  assign outerPolicy = outer_q;
  assign irq = |(status_q & mask_q);
endmodule // fam_fault_addr

// ===== fam_fault_addr_chk.sv
// port assertions for the fault address and attribute decode block
`timescale 1ns/100ps
module fam_fault_addr_chk (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic [11:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [2:0] typeExtensionField, // type bits
  input wire logic regionCacheable, // c bit
  input wire logic regionBufferable, // b bit
  input wire logic regionShareable, // s bit
  input wire fam_pkg::fam_mem_type_t memType, // memory type
  input wire logic memShareable, // shareability
  input wire fam_pkg::fam_policy_t innerPolicy, // inner policy
  input wire fam_pkg::fam_policy_t outerPolicy // outer policy
);
  import fam_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [4:0] attr = {typeExtensionField, regionCacheable, regionBufferable};
  sequence s_acc;
    psel && penable;
  endsequence
  chk_ready_zero: assert property (s_acc |-> pready) else $error("access not ready");
  chk_err_unmapped: assert property (s_acc ##0 paddr > 12'h010 |-> pslverr)
    else $error("unmapped access without error");
  chk_so_decode: assert property (
    attr == 5'h00 |=> memType == FAM_STRONG_ORDER && memShareable)
    else $error("strongly-ordered decode wrong");
  chk_dev_decode: assert property (
    attr == 5'h01 |=> memType == FAM_DEVICE && memShareable)
    else $error("device decode wrong");
  chk_wt_decode: assert property (
    attr == 5'h02 |=> memType == FAM_NORMAL
    && innerPolicy == FAM_WT_NO_ALLOC && outerPolicy == FAM_WT_NO_ALLOC
    && memShareable == $past(regionShareable)) else $error("write-through decode wrong");
  chk_wb_decode: assert property (
    attr == 5'h03 |=> memType == FAM_NORMAL
    && innerPolicy == FAM_WB_NO_ALLOC && outerPolicy == FAM_WB_NO_ALLOC
    && memShareable == $past(regionShareable)) else $error("write-back decode wrong");
  chk_rwa_decode: assert property (
    attr == 5'h07 |=> memType == FAM_NORMAL
    && innerPolicy == FAM_WB_RW_ALLOC && outerPolicy == FAM_WB_RW_ALLOC)
    else $error("allocate decode wrong");
  chk_hi_policy: assert property (
    typeExtensionField[2] |=> memType == FAM_NORMAL
    && outerPolicy == $past(typeExtensionField[1:0])
    && innerPolicy == $past({regionCacheable, regionBufferable}))
    else $error("policy wrong");
endmodule // fam_fault_addr_chk

bind fam_fault_addr fam_fault_addr_chk chk_u (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .typeExtensionField(typeExtensionField), .regionCacheable(regionCacheable),
  .regionBufferable(regionBufferable), .regionShareable(regionShareable), .memType(memType),
  .memShareable(memShareable), .innerPolicy(innerPolicy), .outerPolicy(outerPolicy));

// ===== fam_core_model.sv
// load/store path model that issues fault reports
`timescale 1ns/100ps
module fam_core_model (
  input wire logic core_clk, // clock
  output logic memFault = 1'b0, // mm pulse
  output logic [4:0] memFaultCause = 5'h00, // mm cause
  output logic memFaultAddrOk = 1'b0, // mm addr ok
  output logic [31:0] memFaultAddr = 32'h0, // mm addr
  output logic busFault = 1'b0, // bus pulse
  output logic [5:0] busFaultCause = 6'h00, // bus cause
  output logic busFaultAddrOk = 1'b0, // bus addr ok
  output logic [31:0] busFaultReqAddr = 32'h0 // bus addr
);
  bit act = 1'b0;
  // addresses wander between reports so a stale value never looks held
  always @(posedge core_clk) begin
    if (!act) begin
      memFaultAddr <= ~memFaultAddr;
      busFaultReqAddr <= busFaultReqAddr + 32'h1;
    end
  end
  task automatic fire(input bit isBus, input logic [5:0] c, input bit ok, input logic [31:0] a);
    act = 1'b1;
    @(posedge core_clk);
    memFault <= !isBus;
    busFault <= isBus;
    memFaultCause <= c[4:0];
    busFaultCause <= c;
    memFaultAddrOk <= ok;
    busFaultAddrOk <= ok;
    memFaultAddr <= a;
    busFaultReqAddr <= a;
    @(posedge core_clk);
    memFault <= 1'b0;
    busFault <= 1'b0;
    act = 1'b0;
  endtask
endmodule // fam_core_model

// ===== testbench.sv
// self-checking bench for the fault address block
`include "fam_defs.svh"
`timescale 1ns/100ps
module testbench;
  import fam_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, a;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] typeExtensionField = 3'h0;
  logic regionCacheable = 1'b0, regionBufferable = 1'b0, regionShareable = 1'b0;
  logic pready, pslverr, irq, memShareable, err, memFault, memFaultAddrOk, busFault, busFaultAddrOk;
  fam_mem_type_t memType;
  fam_policy_t innerPolicy, outerPolicy;
  logic [4:0] memFaultCause;
  logic [5:0] busFaultCause, c;
  logic [31:0] memFaultAddr, busFaultReqAddr;
  logic [6:0] gotAttr, expAttr;
  int n_fail = 0, checks_done = 0, seed = 32'hd042c26b, mm = 0, bf = 0, st = 0, msk = 0;
  always #2.5 core_clk = ~core_clk;
  fam_fault_addr dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .memFault(memFault), .memFaultCause(memFaultCause),
    .memFaultAddrOk(memFaultAddrOk), .memFaultAddr(memFaultAddr), .busFault(busFault),
    .busFaultCause(busFaultCause), .busFaultAddrOk(busFaultAddrOk),
    .busFaultReqAddr(busFaultReqAddr), .typeExtensionField(typeExtensionField),
    .regionCacheable(regionCacheable), .regionBufferable(regionBufferable),
    .regionShareable(regionShareable), .memType(memType), .memShareable(memShareable),
    .innerPolicy(innerPolicy), .outerPolicy(outerPolicy), .irq(irq));
  fam_core_model core_u (.core_clk(core_clk), .memFault(memFault), .memFaultCause(memFaultCause),
    .memFaultAddrOk(memFaultAddrOk), .memFaultAddr(memFaultAddr), .busFault(busFault),
    .busFaultCause(busFaultCause), .busFaultAddrOk(busFaultAddrOk),
    .busFaultReqAddr(busFaultReqAddr));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // the wait ends when pready is seen high; the watchdog catches a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected {type, shareable, inner, outer} for the tabled encodings
  function automatic logic [6:0] dec(input logic [5:0] v);
    if (v[5]) return {2'h2, v[0], v[2:1], v[4:3]};
    if (v[5:3] == 3'h0 && !v[2]) return {1'b0, v[1], 1'b1, 4'h0};
    if (v[5:3] == 3'h0) return {2'h2, v[0], v[1] ? 4'hF : 4'hA};
    if (v[5:1] == 5'h04) return {2'h2, v[0], 4'h0};
    if (v[5:1] == 5'h07) return {2'h2, v[0], 4'h5};
    if (v[5:1] == 5'h08) return {2'h1, 1'b0, 4'h0};
    return {2'h3, 1'b0, 4'h0};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    summarize();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i += 4) begin
      apb(1'b0, 12'(i), 32'h0);
      chk("reset value", rd, 32'h0);
      chk("mapped error", err, 1'b0);
    end
    apb(1'b1, `FAM_OFS_MASK, 32'h0000FFFF);
    msk = 'hFFFF;
    // last two reports run masked and without a valid address
    for (int k = 0; k < 6; k++) begin
      a = $random(seed);
      c = 6'($random(seed));
      if (k == 4) begin
        apb(1'b1, `FAM_OFS_MASK, 32'h0);
        msk = 0;
      end
      core_u.fire(k[0], c, k < 2, a);
      if (k[0]) begin
        st = {(k < 2), 1'b0, c, 8'h00};
        if (k < 2) bf = a;
      end else begin
        st = {(k < 2), 2'h0, c[4:0]};
        if (k < 2) mm = a;
      end
      @(posedge core_clk);
      #1 chk("irq raised", irq, (st & msk) != 0);
      apb(1'b0, `FAM_OFS_MMADDR, 32'h0);
      chk("mm address", rd, mm);
      apb(1'b0, `FAM_OFS_BFADDR, 32'h0);
      chk("bus address", rd, bf);
      apb(1'b0, `FAM_OFS_STATUS, 32'h0);
      chk("status", rd, st);
      @(posedge core_clk);
      #1 chk("irq cleared", irq, 1'b0);
    end
    a = $random(seed);
    apb(1'b1, `FAM_OFS_MMADDR, a);
    apb(1'b0, `FAM_OFS_MMADDR, 32'h0);
    chk("mm written", rd, a);
    apb(1'b1, `FAM_OFS_STATUS, 32'h0000FFFF);
    apb(1'b0, `FAM_OFS_STATUS, 32'h0);
    chk("status read-only", rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped error", err, 1'b1);
    for (int i = 0; i < 64; i++) begin
      @(posedge core_clk);
      {typeExtensionField, regionCacheable, regionBufferable, regionShareable} <= 6'(i);
      @(posedge core_clk);
      #1;
      gotAttr = {memType, memShareable, innerPolicy, outerPolicy};
      chk("attr decode", gotAttr, dec(6'(i)));
    end
    apb(1'b0, `FAM_OFS_ATTR, 32'h0);
    expAttr = dec(6'h3F);
    chk("attr readback", rd, {18'h0, expAttr[1:0], 2'h0, expAttr[3:2], 2'h0,
      expAttr[6:5], 3'h0, expAttr[4]});
    summarize();
  end
endmodule // testbench
